// file: hda_pkg.sv
// Package with constants and types for the harmonic distortion alarm supervisor
// Functional notes
// - Report supervision state per group: normal, start, alarm or blocked.
// - Sample the blocking input once per processing cycle and hold it.
// - Pick-up without blocking asserts start and begins the delay timer.
// - Pick-up with blocking asserts blocked, never start or alarm.
// - Blocking during start drops start as if pick-up had released.
// - Alarm asserts only after start stayed on for the whole delay.
// - Separate delays per group, 0 to 1800 s in 5 ms steps, default 10 s.
// - Per event, configuration selects emitting its ON, OFF edge or both on the event stream.
// - Each event carries a time stamp taken at its status change.
// - Clearable cumulative counters for start, alarm and blocked occurrences.
// - Circular log of twelve records, written only on ON edges.
// - Log record holds time in ms, event id, phase values, setting group.
// - Start, alarm and blocked are plain binary outputs.
// - Pick-up when value exceeds threshold; any phase suffices for phase group.
// - Release only when value falls below 97 percent of threshold.
// - Each element has its own enable; disabled means no start or alarm.
// - One shared setting selects amplitude or power ratio for all channels.
package hda_pkg;
  // ==========================================================
  // Sizes
  localparam int HDA_NGRP = 3;
  localparam int HDA_NCH = 5;
  localparam int HDA_VW = 16;
  localparam int HDA_TW = 14;
  localparam int HDA_DW = 19;
  localparam int HDA_NEV = 14;
  localparam int HDA_LOG_N = 12;
  localparam int HDA_TSW = 32;
  // ==========================================================
  // Timing: delay register counts processing cycles
  localparam int HDA_CYCLE_MS = 5;
  localparam int HDA_DLY_DEF_MS = 10000;
  localparam int HDA_DLY_MAX_MS = 1800000;
  localparam logic [18:0] HDA_DLY_DEF = 19'(HDA_DLY_DEF_MS / HDA_CYCLE_MS);
  localparam logic [18:0] HDA_DLY_MAX = 19'(HDA_DLY_MAX_MS / HDA_CYCLE_MS);
  // Release ratio in percent
  localparam int HDA_REL_PCT = 97;
  localparam int HDA_PCT = 100;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] HDA_CTRL = 8'h00;
  localparam logic [7:0] HDA_THR0 = 8'h04;
  localparam logic [7:0] HDA_DLY0 = 8'h10;
  localparam logic [7:0] HDA_EVMASK = 8'h1C;
  localparam logic [7:0] HDA_STATUS = 8'h20;
  localparam logic [7:0] HDA_CNT0 = 8'h24;
  localparam logic [7:0] HDA_CNT_CLR = 8'h30;
  localparam logic [7:0] HDA_LOG_SEL = 8'h34;
  localparam logic [7:0] HDA_LOG_TIME = 8'h38;
  localparam logic [7:0] HDA_LOG_INFO = 8'h3C;
  localparam logic [7:0] HDA_LOG_P12 = 8'h40;
  localparam logic [7:0] HDA_LOG_P3 = 8'h44;
  localparam logic [7:0] HDA_LOG_CNT = 8'h48;
  // ==========================================================
  // Field positions and reset values
  localparam int HDA_CTRL_PWR = 3;
  localparam logic [2:0] HDA_EN_RST = 3'h7;
  localparam logic [13:0] HDA_THR_RST = 14'h03E8;
  localparam logic [13:0] HDA_EVMASK_RST = 14'h3FFF;
  // ==========================================================
  // Supervision state of one group
  typedef enum logic [1:0] {HDA_NORMAL, HDA_START, HDA_ALARM, HDA_BLOCKED} hda_state_e;
endpackage

// file: hda_element.sv
// One alarm element: hysteresis pick-up, blocking and definite delay
`timescale 1ns/1ps
module hda_element
  import hda_pkg::*;
#(
  parameter int VW = HDA_VW,
  parameter int TW = HDA_TW,
  parameter int DW = HDA_DW
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Cycle tick and settings
  input wire logic tick,
  input wire logic enable,
  input wire logic block_s,
  input wire logic [VW-1:0] value,
  input wire logic [TW-1:0] thresh,
  input wire logic [DW-1:0] delay,
  // Element outputs
  output logic start_q,
  output logic alarm_q,
  output logic blocked_q,
  output hda_state_e state_q
);
  logic pick_q, pick_d, start_d, alarm_d, blocked_d;
  logic [DW-1:0] cnt_q, cnt_d;
  logic [23:0] val_pct, rel_lim;
  hda_state_e state_d;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Next state, evaluated only on the processing tick
  always_comb
  begin
    val_pct = 24'(value) * 24'(HDA_PCT);
    rel_lim = 24'(thresh) * 24'(HDA_REL_PCT);
    pick_d = pick_q;
    start_d = start_q;
    alarm_d = alarm_q;
    blocked_d = blocked_q;
    cnt_d = cnt_q;
    if (tick)
    begin
      // Disabled element stays quiet
      if (!enable)
        pick_d = 1'b0;
      else if (pick_q)
        pick_d = !(val_pct < rel_lim);
      else
        pick_d = value > VW'(thresh);
      start_d = 1'b0;
      alarm_d = 1'b0;
      blocked_d = 1'b0;
      cnt_d = '0; // Release restarts the timer
      if (pick_d && !block_s)
      begin
        start_d = 1'b1;
        cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
        alarm_d = cnt_d >= delay;
      end
      else if (pick_d && block_s)
        blocked_d = 1'b1; // Start dropped like a release
    end
    // Reported state, alarm outranks start
    if (alarm_d)
      state_d = HDA_ALARM;
    else if (start_d)
      state_d = HDA_START;
    else if (blocked_d)
      state_d = HDA_BLOCKED;
    else
      state_d = HDA_NORMAL;
  end

  // Register stage
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pick_q <= 1'b0;
      start_q <= 1'b0;
      alarm_q <= 1'b0;
      blocked_q <= 1'b0;
      cnt_q <= '0;
      state_q <= HDA_NORMAL;
    end
    else
    begin
      pick_q <= pick_d;
      start_q <= start_d;
      alarm_q <= alarm_d;
      blocked_q <= blocked_d;
      cnt_q <= cnt_d;
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Checks
  chk_block_excl: assert property (blocked_q |-> !start_q && !alarm_q)
    else $error("blocked together with start or alarm");
  chk_alarm_start: assert property (alarm_q |-> start_q && cnt_q >= delay)
    else $error("alarm without full delay");
  chk_disabled_quiet: assert property (tick && !enable |=> !start_q && !alarm_q)
    else $error("disabled element active");
  chk_start_block: assert property (tick && block_s |=> !start_q)
    else $error("start survived blocking");
  chk_timer_hold: assert property (!tick |=> $stable(cnt_q) && $stable(start_q))
    else $error("timer moved between ticks");
endmodule

// file: hda_supervisor.sv
// Top of the harmonic distortion alarm supervisor with register port
`timescale 1ns/1ps
module hda_supervisor
  import hda_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Measurements: 0..2 phases, 3 residual one, 4 residual two
  input wire logic cycle_tick,
  input wire logic [HDA_NCH-1:0][HDA_VW-1:0] meas_amp,
  input wire logic [HDA_NCH-1:0][HDA_VW-1:0] meas_pow,
  input wire logic block_in,
  input wire logic [HDA_TSW-1:0] time_ms,
  input wire logic [2:0] setting_group,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata_q,
  // Binary outputs, 0 phase, 1 residual one, 2 residual two
  output logic [HDA_NGRP-1:0] start_q,
  output logic [HDA_NGRP-1:0] alarm_q,
  output logic blocked_q,
  output hda_state_e distortion_supervision_state_q,
  // Event stream
  output logic event_valid_q,
  output logic [3:0] event_id_q,
  output logic [HDA_TSW-1:0] event_time_q
);
  localparam int NLV = 7;

  // ==========================================================
  // Configuration registers
  logic [2:0] en_q, en_d;
  logic pwr_q, pwr_d;
  logic [HDA_NGRP-1:0][HDA_TW-1:0] thr_q, thr_d;
  logic [HDA_NGRP-1:0][HDA_DW-1:0] dly_q, dly_d;
  logic [HDA_NEV-1:0] evmask_q, evmask_d;
  logic [3:0] logsel_q, logsel_d;
  logic [2:0][31:0] cnt_q, cnt_d;
  logic [31:0] rdata_d;
  logic blk_q, blk_d;

  // Element outputs
  logic [HDA_NGRP-1:0] e_start, e_alarm, e_blk;
  hda_state_e e_state [HDA_NGRP];
  logic [HDA_NGRP-1:0][HDA_VW-1:0] grp_val;
  logic [HDA_NCH-1:0][HDA_VW-1:0] sel_val;

  // Output stage and events
  logic [HDA_NGRP-1:0] start_d, alarm_d;
  logic blocked_d, ev_valid_d;
  hda_state_e sup_state_d;
  logic [NLV-1:0] lvl_now, lvl_q;
  logic [HDA_NEV-1:0] pend_q, pend_d, ev_new, served;
  logic [HDA_TSW-1:0] ptime_q, ptime_d, ev_time_d;
  logic [2:0][HDA_VW-1:0] psnap_q, psnap_d;
  logic [3:0] ev_id_d, sel_id;
  logic sel_any, log_wr;

  // Log storage
  logic [HDA_TSW-1:0] log_time [HDA_LOG_N];
  logic [6:0] log_info [HDA_LOG_N];
  logic [2:0][HDA_VW-1:0] log_ph [HDA_LOG_N];
  logic [3:0] wptr_q, wptr_d, lcnt_q, lcnt_d, ridx;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Larger of two values, used twice for the phase group
  function automatic logic [HDA_VW-1:0] vmax(input logic [HDA_VW-1:0] a, b);
    vmax = (a > b) ? a : b;
  endfunction

  // ==========================================================
  // Ratio select and group values
  always_comb
  begin
    sel_val = pwr_q ? meas_pow : meas_amp;
    grp_val[0] = vmax(vmax(sel_val[0], sel_val[1]), sel_val[2]); // Any phase picks up
    grp_val[1] = sel_val[3];
    grp_val[2] = sel_val[4];
  end

  // One element per group, each with its own delay
  for (genvar g = 0; g < HDA_NGRP; g++)
  begin : g_elem
    hda_element #(.VW(HDA_VW), .TW(HDA_TW), .DW(HDA_DW)) u_elem (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .tick(cycle_tick),
      .enable(en_q[g]),
      .block_s(block_in), // Taken only on the tick edge
      .value(grp_val[g]),
      .thresh(thr_q[g]),
      .delay(dly_q[g]),
      .start_q(e_start[g]),
      .alarm_q(e_alarm[g]),
      .blocked_q(e_blk[g]),
      .state_q(e_state[g])
    );
  end

  // ==========================================================
  // Output stage, straight from flip-flops
  always_comb
  begin
    start_d = e_start;
    alarm_d = e_alarm;
    blocked_d = |e_blk;
    blk_d = cycle_tick ? block_in : blk_q; // Held for the cycle
    // Overall state, worst group wins
    if (|e_alarm)
      sup_state_d = HDA_ALARM;
    else if (|e_start)
      sup_state_d = HDA_START;
    else if (|e_blk)
      sup_state_d = HDA_BLOCKED;
    else
      sup_state_d = HDA_NORMAL;
  end

  // ==========================================================
  // Edge detection and pending events
  always_comb
  begin
    lvl_now = {blocked_q, alarm_q, start_q};
    ev_new = '0;
    for (int i = 0; i < NLV; i++)
    begin
      ev_new[2*i] = lvl_now[i] && !lvl_q[i];
      ev_new[2*i+1] = !lvl_now[i] && lvl_q[i];
    end
    sel_any = 1'b0;
    sel_id = '0;
    for (int i = HDA_NEV - 1; i >= 0; i--)
    begin
      if (pend_q[i])
      begin
        sel_any = 1'b1;
        sel_id = 4'(i);
      end
    end
    served = '0;
    if (sel_any)
      served[sel_id] = 1'b1;
    // New edges win over the bit being served
    pend_d = (pend_q & ~served) | ev_new;
    // Stamp at the change; events of one tick share it
    ptime_d = (|ev_new) ? time_ms : ptime_q;
    psnap_d = (|ev_new) ? sel_val[2:0] : psnap_q;
    ev_valid_d = sel_any && evmask_q[sel_id];
    ev_id_d = sel_any ? sel_id : event_id_q;
    ev_time_d = sel_any ? ptime_q : event_time_q;
    log_wr = sel_any && !sel_id[0]; // ON edges only
  end

  // ==========================================================
  // Log pointer and fill count, newest record read at index 0
  always_comb
  begin
    wptr_d = wptr_q;
    lcnt_d = lcnt_q;
    if (log_wr)
    begin
      wptr_d = (wptr_q == 4'(HDA_LOG_N - 1)) ? 4'h0 : wptr_q + 4'h1;
      lcnt_d = (lcnt_q == 4'(HDA_LOG_N)) ? lcnt_q : lcnt_q + 4'h1;
    end
    ridx = 4'((32'(wptr_q) + 32'(2 * HDA_LOG_N) - 32'd1 - 32'(logsel_q)) % HDA_LOG_N);
  end

  // Log memory, no reset needed, unread until written
  always_ff @(posedge ref_clk)
  begin
    if (log_wr)
    begin
      log_time[wptr_q] <= ptime_q;
      log_info[wptr_q] <= {setting_group, sel_id};
      log_ph[wptr_q] <= psnap_q;
    end
  end

  // ==========================================================
  // Register writes, counters and read mux
  always_comb
  begin
    en_d = en_q;
    pwr_d = pwr_q;
    thr_d = thr_q;
    dly_d = dly_q;
    evmask_d = evmask_q;
    logsel_d = logsel_q;
    cnt_d = cnt_q;
    rdata_d = 32'h0;
    if (wr_en)
    begin
      case (addr)
        HDA_CTRL:
        begin
          en_d = wdata[2:0];
          pwr_d = wdata[HDA_CTRL_PWR];
        end
        HDA_EVMASK: evmask_d = wdata[HDA_NEV-1:0];
        // Whole word compared so that out-of-range selects never alias into the log
        HDA_LOG_SEL: logsel_d = (wdata < 32'(HDA_LOG_N)) ? wdata[3:0] : logsel_q;
        HDA_CNT_CLR:
        begin
          for (int k = 0; k < 3; k++)
            if (wdata[k])
              cnt_d[k] = 32'h0;
        end
        default:
        begin
          for (int k = 0; k < HDA_NGRP; k++)
          begin
            if (addr == HDA_THR0 + 8'(4 * k))
              thr_d[k] = wdata[HDA_TW-1:0];
            // Delays above the range saturate at the top
            if (addr == HDA_DLY0 + 8'(4 * k))
              dly_d[k] = (wdata > 32'(HDA_DLY_MAX)) ? HDA_DLY_MAX : wdata[HDA_DW-1:0];
          end
        end
      endcase
    end
    // Count ON edges after a clear, so a same-cycle event is kept
    if (log_wr)
    begin
      if (sel_id < 4'd6)
        cnt_d[0] = cnt_d[0] + 32'h1;
      else if (sel_id < 4'd12)
        cnt_d[1] = cnt_d[1] + 32'h1;
      else
        cnt_d[2] = cnt_d[2] + 32'h1;
    end
    if (rd_en)
    begin
      case (addr)
        HDA_CTRL: rdata_d = {28'h0, pwr_q, en_q};
        HDA_EVMASK: rdata_d = {18'h0, evmask_q};
        // Group states, outputs and sampled block level
        HDA_STATUS: rdata_d = {18'h0, blk_q, blocked_q, alarm_q, start_q,
                               e_state[2], e_state[1], e_state[0]};
        HDA_LOG_SEL: rdata_d = {28'h0, logsel_q};
        HDA_LOG_TIME: rdata_d = (logsel_q < lcnt_q) ? log_time[ridx] : 32'h0;
        HDA_LOG_INFO: rdata_d = (logsel_q < lcnt_q) ? {25'h0, log_info[ridx]} : 32'h0;
        HDA_LOG_P12: rdata_d = (logsel_q < lcnt_q) ? {log_ph[ridx][1], log_ph[ridx][0]} : 32'h0;
        HDA_LOG_P3: rdata_d = (logsel_q < lcnt_q) ? {16'h0, log_ph[ridx][2]} : 32'h0;
        HDA_LOG_CNT: rdata_d = {28'h0, lcnt_q};
        default:
        begin
          for (int k = 0; k < 3; k++)
          begin
            if (addr == HDA_THR0 + 8'(4 * k))
              rdata_d = {18'h0, thr_q[k]};
            if (addr == HDA_DLY0 + 8'(4 * k))
              rdata_d = {13'h0, dly_q[k]};
            if (addr == HDA_CNT0 + 8'(4 * k))
              rdata_d = cnt_q[k];
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Register stage
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_q <= HDA_EN_RST;
      pwr_q <= 1'b0;
      thr_q <= {HDA_NGRP{HDA_THR_RST}};
      dly_q <= {HDA_NGRP{HDA_DLY_DEF}};
      evmask_q <= HDA_EVMASK_RST;
      logsel_q <= 4'h0;
      cnt_q <= '0;
      rdata_q <= 32'h0;
      blk_q <= 1'b0;
      start_q <= '0;
      alarm_q <= '0;
      blocked_q <= 1'b0;
      distortion_supervision_state_q <= HDA_NORMAL;
      lvl_q <= '0;
      pend_q <= '0;
      ptime_q <= '0;
      psnap_q <= '0;
      event_valid_q <= 1'b0;
      event_id_q <= 4'h0;
      event_time_q <= '0;
      wptr_q <= 4'h0;
      lcnt_q <= 4'h0;
    end
    else
    begin
      en_q <= en_d;
      pwr_q <= pwr_d;
      thr_q <= thr_d;
      dly_q <= dly_d;
      evmask_q <= evmask_d;
      logsel_q <= logsel_d;
      cnt_q <= cnt_d;
      rdata_q <= rdata_d;
      blk_q <= blk_d;
      start_q <= start_d;
      alarm_q <= alarm_d;
      blocked_q <= blocked_d;
      distortion_supervision_state_q <= sup_state_d;
      lvl_q <= lvl_now;
      pend_q <= pend_d;
      ptime_q <= ptime_d;
      psnap_q <= psnap_d;
      event_valid_q <= ev_valid_d;
      event_id_q <= ev_id_d;
      event_time_q <= ev_time_d;
      wptr_q <= wptr_d;
      lcnt_q <= lcnt_d;
    end
  end

  // ==========================================================
  // Checks
  chk_event_mask: assert property (event_valid_q |-> evmask_q[event_id_q])
    else $error("masked event emitted");
  chk_event_edge: assert property (start_q[0] && !$past(start_q[0]) |-> ##1 pend_q[0])
    else $error("start edge not queued");
  chk_log_ptr: assert property (wptr_q < 4'(HDA_LOG_N) && lcnt_q <= 4'(HDA_LOG_N))
    else $error("log pointer out of range");
  chk_blocked_out: assert property (blocked_q |-> !(|start_q))
    else $error("blocked output with start");
endmodule

// file: hda_meas_model.sv
// Measurement source and blocking matrix model facing the supervisor
`timescale 1ns/1ps
module hda_meas_model
  import hda_pkg::*;
#(
  parameter int PER = 32
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Values the bench asks for
  input wire logic [HDA_NCH-1:0][HDA_VW-1:0] set_amp,
  input wire logic [HDA_NCH-1:0][HDA_VW-1:0] set_pow,
  input wire logic set_block,
  // Towards the supervisor
  output logic cycle_tick,
  output logic [HDA_NCH-1:0][HDA_VW-1:0] meas_amp,
  output logic [HDA_NCH-1:0][HDA_VW-1:0] meas_pow,
  output logic block_in,
  output logic [HDA_TSW-1:0] time_ms
);
  int cnt;
  // ==========================================================
  // Processing cycle, refresh and time stamp
  // Values refresh before the tick so they are settled when sampled
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 0;
      cycle_tick <= 1'b0;
      meas_amp <= '0;
      meas_pow <= '0;
      block_in <= 1'b0;
      time_ms <= 32'h0000_0000;
    end
    else
    begin
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
      cycle_tick <= (cnt == PER - 1);
      if (cnt == PER - 3)
      begin
        meas_amp <= set_amp;
        meas_pow <= set_pow;
        block_in <= set_block; // Always ahead of the tick, never late
      end
      if (cnt == PER - 1)
        time_ms <= time_ms + 32'(HDA_CYCLE_MS);
    end
  end
endmodule

// file: hda_supervisor_tb_top.sv
// Self-checking bench for the harmonic distortion alarm supervisor
`timescale 1ns/1ps
module hda_supervisor_tb_top
  import hda_pkg::*;
;
  // ==========================================================
  // Signals
  logic ref_clk;
  logic resetn;
  logic cycle_tick;
  logic [HDA_NCH-1:0][HDA_VW-1:0] meas_amp;
  logic [HDA_NCH-1:0][HDA_VW-1:0] meas_pow;
  logic [HDA_NCH-1:0][HDA_VW-1:0] set_amp;
  logic [HDA_NCH-1:0][HDA_VW-1:0] set_pow;
  logic set_block;
  logic block_in;
  logic [HDA_TSW-1:0] time_ms;
  logic [2:0] setting_group;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata_q;
  logic [HDA_NGRP-1:0] start_q;
  logic [HDA_NGRP-1:0] alarm_q;
  logic blocked_q;
  hda_state_e state_q;
  logic event_valid_q;
  logic [3:0] event_id_q;
  logic [HDA_TSW-1:0] event_time_q;
  logic [3:0] ev_id[$];
  logic [HDA_TSW-1:0] ev_t[$];
  logic [HDA_TSW-1:0] t_on;
  logic [HDA_TSW-1:0] t_al;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  // ==========================================================
  // Design and source model
  hda_supervisor dut_u (.ref_clk(ref_clk), .resetn(resetn), .cycle_tick(cycle_tick),
    .meas_amp(meas_amp), .meas_pow(meas_pow), .block_in(block_in), .time_ms(time_ms),
    .setting_group(setting_group), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_q(rdata_q), .start_q(start_q), .alarm_q(alarm_q),
    .blocked_q(blocked_q), .distortion_supervision_state_q(state_q),
    .event_valid_q(event_valid_q), .event_id_q(event_id_q), .event_time_q(event_time_q));
  hda_meas_model #(.PER(32)) model_u (.ref_clk(ref_clk), .resetn(resetn), .set_amp(set_amp),
    .set_pow(set_pow), .set_block(set_block), .cycle_tick(cycle_tick), .meas_amp(meas_amp),
    .meas_pow(meas_pow), .block_in(block_in), .time_ms(time_ms));
  // ==========================================================
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Event capture and hang guard; ceiling well above the run length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (event_valid_q === 1'b1)
    begin
      ev_id.push_back(event_id_q);
      ev_t.push_back(event_time_q);
    end
    if (cycles == 5000)
    begin
      mismatches++;
      $display("[ERR] %0t run did not finish", $time);
      wrap_up();
    end
  end
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    check(rdata_q, exp, what);
  endtask
  // Wait for the next processing tick and let events drain
  task automatic tk();
    @(posedge ref_clk iff cycle_tick === 1'b1);
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task automatic outs(input logic [2:0] s, input logic [2:0] a, input logic b,
                      input hda_state_e st, input string what);
    check({29'h0, start_q}, {29'h0, s}, what);
    check({29'h0, alarm_q}, {29'h0, a}, what);
    check({31'h0, blocked_q}, {31'h0, b}, what);
    check({30'h0, state_q}, {30'h0, st}, what);
  endtask
  task automatic wrap_up();
    $display("Totals: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Test sequence
  initial
  begin
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    set_amp = '0;
    set_pow = '0;
    set_block = 1'b0;
    setting_group = 3'h5;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    outs(3'h0, 3'h0, 1'b0, HDA_NORMAL, "after reset");
    rd_chk(HDA_CTRL, 32'h0000_0007, "enables");
    rd_chk(HDA_THR0, 32'h0000_03E8, "threshold");
    rd_chk(HDA_DLY0, {13'h0, HDA_DLY_DEF}, "default delay");
    rd_chk(HDA_EVMASK, 32'h0000_3FFF, "event mask");
    rd_chk(8'hFC, 32'h0000_0000, "unmapped");
    wr(HDA_DLY0 + 8'h08, 32'h000F_FFFF);
    rd_chk(HDA_DLY0 + 8'h08, {13'h0, HDA_DLY_MAX}, "delay ceiling");
    wr(HDA_DLY0, 32'h0000_0003);
    wr(HDA_DLY0 + 8'h04, 32'h0000_0001);
    wr(HDA_CNT_CLR, 32'h0000_0007);
    $display("test reset_values done");
    // Phase group: one phase over the limit, hysteresis boundary, release
    tk();
    ev_id.delete();
    ev_t.delete();
    set_amp[2] = 16'd1001;
    tk();
    t_on = time_ms;
    outs(3'h1, 3'h0, 1'b0, HDA_START, "phase start");
    tk();
    outs(3'h1, 3'h0, 1'b0, HDA_START, "before expiry");
    tk();
    t_al = time_ms;
    outs(3'h1, 3'h1, 1'b0, HDA_ALARM, "phase alarm");
    rd_chk(HDA_STATUS, 32'h0000_0242, "status alarm");
    set_amp[2] = 16'd970;
    tk();
    outs(3'h1, 3'h1, 1'b0, HDA_ALARM, "at release ratio");
    set_amp[2] = 16'd969;
    tk();
    outs(3'h0, 3'h0, 1'b0, HDA_NORMAL, "released");
    check(ev_id.size(), 32'd4, "event count");
    if (ev_id.size() == 4)
    begin
      check({ev_id[0], ev_id[1], ev_id[2], ev_id[3]}, 32'h0000_0617, "event ids");
      check(ev_t[0], t_on, "event stamp");
    end
    rd_chk(HDA_CNT0, 32'd1, "start count");
    rd_chk(HDA_CNT0 + 8'h04, 32'd1, "alarm count");
    rd_chk(HDA_LOG_CNT, 32'd2, "log fill");
    wr(HDA_LOG_SEL, 32'h0000_0000);
    rd_chk(HDA_LOG_INFO, 32'h0000_0056, "log newest");
    rd_chk(HDA_LOG_TIME, t_al, "log time");
    rd_chk(HDA_LOG_P3, 32'd1001, "log phase value");
    $display("test phase_definite_time done");
    // Residual one: one-cycle delay, blocking in mid-start
    tk();
    set_amp[3] = 16'd1500;
    tk();
    outs(3'h2, 3'h2, 1'b0, HDA_ALARM, "short delay");
    set_block = 1'b1;
    tk();
    outs(3'h0, 3'h0, 1'b1, HDA_BLOCKED, "block after start");
    set_block = 1'b0;
    tk();
    outs(3'h2, 3'h2, 1'b0, HDA_ALARM, "unblocked");
    set_amp[3] = 16'd0;
    tk();
    outs(3'h0, 3'h0, 1'b0, HDA_NORMAL, "residual release");
    rd_chk(HDA_CNT0 + 8'h08, 32'd1, "blocked count");
    // Residual two: blocking and pick-up arriving on the same tick
    set_block = 1'b1;
    set_amp[4] = 16'd1500;
    tk();
    outs(3'h0, 3'h0, 1'b1, HDA_BLOCKED, "blocked first");
    rd_chk(HDA_STATUS, 32'h0000_3030, "status blocked");
    set_block = 1'b0;
    set_amp[4] = 16'd0;
    tk();
    outs(3'h0, 3'h0, 1'b0, HDA_NORMAL, "block gone");
    $display("test blocking done");
    // Phase element disabled while residual one still works
    tk();
    wr(HDA_CTRL, 32'h0000_0006);
    set_amp[0] = 16'd2000;
    set_amp[3] = 16'd1500;
    tk();
    outs(3'h2, 3'h2, 1'b0, HDA_ALARM, "phase disabled");
    set_amp[3] = 16'd0;
    tk();
    // Power ratio selected, off edge of phase start masked
    wr(HDA_CTRL, 32'h0000_000F);
    wr(HDA_EVMASK, 32'h0000_3FFD);
    ev_id.delete();
    tk();
    outs(3'h0, 3'h0, 1'b0, HDA_NORMAL, "amplitude ignored");
    set_pow[0] = 16'd2000;
    tk();
    outs(3'h1, 3'h0, 1'b0, HDA_START, "power ratio");
    set_amp[0] = 16'd0;
    set_pow[0] = 16'd0;
    tk();
    outs(3'h0, 3'h0, 1'b0, HDA_NORMAL, "power release");
    check(ev_id.size(), 32'd1, "masked events");
    wr(HDA_CNT_CLR, 32'h0000_0007);
    rd_chk(HDA_CNT0, 32'd0, "count cleared");
    $display("test enable_power_mask done");
    wrap_up();
  end
endmodule
